// ### core/codec_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface codec_ctrl_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host   (output addr, output wdata, output wr, output rd,
                  input rdata);
endinterface
`default_nettype wire

// ### core/codec_host_ctrl.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module codec_host_ctrl (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [3:0]  sw_addr_i,
  input  wire logic [31:0] sw_wdata_i,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_rd_i,
  output logic [31:0]      sw_rdata_o,
  output logic             irq_o,
  codec_ctrl_if.host       bus
);

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  localparam int NE = codec_regs_pkg::NUM_EVT;

  codec_regs_pkg::host_state_e state_reg;
  logic [6:0]    addr_reg;
  logic [7:0]    wdata_reg;
  logic          is_wr_reg;
  logic [7:0]    rdata_reg;
  logic [NE-1:0] status_reg;
  logic [NE-1:0] irq_en_reg;
  logic [31:0]   sw_rdata_reg;

  wire cmd_wr   = sw_wr_i && sw_addr_i == codec_regs_pkg::HOST_CMD;
  wire go_wr    = cmd_wr & sw_wdata_i[codec_regs_pkg::CMD_WR_BIT];
  wire go_rd    = cmd_wr & sw_wdata_i[codec_regs_pkg::CMD_RD_BIT];
  wire idle     = state_reg == codec_regs_pkg::H_IDLE;
  wire go       = idle & (go_wr ^ go_rd);
  // Writes to the reserved range are refused only with bit 15 set; with it clear they reach the bus
  wire to_rsvd  = sw_wdata_i[14:8] >= codec_regs_pkg::IDX_RSVD_FIRST;
  wire refuse   = cmd_wr & (~idle | (go_wr & go_rd) |
                  (go_wr & to_rsvd & sw_wdata_i[15]));
  wire pg_write = is_wr_reg && addr_reg == codec_regs_pkg::IDX_PAGE;
  wire pg_bad   = bus.rdata[codec_regs_pkg::BIT_PAGE] !=
                  wdata_reg[codec_regs_pkg::BIT_PAGE];

  logic [NE-1:0] evt;
  always_comb begin
    evt = '0;
    evt[codec_regs_pkg::ST_DONE]     =
      (state_reg == codec_regs_pkg::H_WAIT) |
      (state_reg == codec_regs_pkg::H_VERIFY);
    evt[codec_regs_pkg::ST_REFUSED]  = refuse;
    evt[codec_regs_pkg::ST_PAGE_BAD] =
      (state_reg == codec_regs_pkg::H_VERIFY) & pg_bad;
  end

  // Bit 15 of a command marks it as page-zero space
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= codec_regs_pkg::H_IDLE;
      addr_reg  <= 7'h00;
      wdata_reg <= 8'h00;
      is_wr_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      case (state_reg)
        codec_regs_pkg::H_IDLE: begin
          if (go && !refuse) begin
            addr_reg  <= sw_wdata_i[14:8];
            wdata_reg <= sw_wdata_i[7:0];
            is_wr_reg <= go_wr;
            state_reg <= codec_regs_pkg::H_ISSUE;
          end
        end
        codec_regs_pkg::H_ISSUE: begin
          // Page writes are read back to confirm the active page
          state_reg <= codec_regs_pkg::H_WAIT;
        end
        codec_regs_pkg::H_WAIT: begin
          rdata_reg <= bus.rdata;
          state_reg <= pg_write ? codec_regs_pkg::H_VERIFY
                                : codec_regs_pkg::H_IDLE;
        end
        codec_regs_pkg::H_VERIFY: begin
          rdata_reg <= bus.rdata;
          state_reg <= codec_regs_pkg::H_IDLE;
        end
        default: state_reg <= codec_regs_pkg::H_IDLE;
      endcase
    end
  end

  // Issue one write or read, then for a page write a read-back of index zero
  assign bus.addr  = addr_reg;
  assign bus.wdata = wdata_reg;
  assign bus.wr    = (state_reg == codec_regs_pkg::H_ISSUE) & is_wr_reg;
  assign bus.rd    = ((state_reg == codec_regs_pkg::H_ISSUE) & ~is_wr_reg) |
                     ((state_reg == codec_regs_pkg::H_WAIT) & pg_write);

  // ----------------------------------------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------------------------------------
  wire clr_wr = sw_wr_i && sw_addr_i == codec_regs_pkg::HOST_IRQ_CLR;
  wire en_wr  = sw_wr_i && sw_addr_i == codec_regs_pkg::HOST_IRQ_EN;
  wire [NE-1:0] clr_mask = clr_wr ? sw_wdata_i[NE-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_reg <= '0;
      irq_en_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clr_mask) | evt;
      if (en_wr)
        irq_en_reg <= sw_wdata_i[NE-1:0];
    end
  end

  wire [31:0] sw_mux =
    sw_addr_i == codec_regs_pkg::HOST_RDATA  ? {24'h00_0000, rdata_reg} :
    sw_addr_i == codec_regs_pkg::HOST_STATUS ? {29'h0, status_reg} :
    sw_addr_i == codec_regs_pkg::HOST_IRQ_EN ? {29'h0, irq_en_reg} :
    sw_addr_i == codec_regs_pkg::HOST_CMD    ? {31'h0, ~idle} :
    32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (srst_i)
      sw_rdata_reg <= 32'h0000_0000;
    else if (sw_rd_i)
      sw_rdata_reg <= sw_mux;
  end

  assign sw_rdata_o = sw_rdata_reg;
  assign irq_o      = |(status_reg & irq_en_reg);

endmodule
`default_nettype wire

// ### core/codec_misc_config_page_regs.sv
// What this block does
// - Left coefficient bit picks default or programmable
// - Right coefficient bit picks default or programmable
// - Two-bit field picks each channel microphone type
// - Programmable filter attached only with DACs down
// - Detector bit two set disables bus error detection
// - Error status sets on error, clears on read
// - Right bypass bits close right output switches
// - Left bypass bits close left output switches
// - Host avoids shorting both input pairs together
// - Two-bit field trims DAC reference current
// - Host writes zeros to reserved bits
// - Reserved range reads zero, never written; the host refuses such writes only with command bit 15 set
// - Page bit steers later accesses to page
// - Page register identical on both pages
// - Host reads page bit back after writing
// - Configuration fields reset to zero
// - Host writes coefficient high byte then low
`timescale 1ns/1ps
`default_nettype none
module codec_misc_config_page_regs (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  codec_ctrl_if.device    bus,
  input  wire logic       bus_error_i,
  input  wire logic       dacs_powered_down_i,
  input  wire logic       hpf_enable_i,
  output logic            page_one_o,
  output logic            left_prog_coef_o,
  output logic            right_prog_coef_o,
  output logic            left_analog_mic_o,
  output logic            right_analog_mic_o,
  output logic            prog_filter_on_adc_o,
  output logic            bus_error_clear_o,
  output logic [3:0]      right_bypass_o,
  output logic [3:0]      left_bypass_o,
  output logic [1:0]      dac_current_trim_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] adc_path_reg;
  logic [7:0] bypass_reg;
  logic [7:0] dac_cur_reg;
  logic       page_reg;
  logic       bus_err_reg;
  logic [7:0] rdata_reg;

  // Page-zero decode; page one holds coefficients outside this slice
  wire        on_page0   = ~page_reg;
  wire        hit_page   = bus.addr == codec_regs_pkg::IDX_PAGE;
  wire        hit_adc    = on_page0 &&
                           bus.addr == codec_regs_pkg::IDX_ADC_PATH;
  wire        hit_byp    = on_page0 &&
                           bus.addr == codec_regs_pkg::IDX_BYPASS;
  wire        hit_dac    = on_page0 &&
                           bus.addr == codec_regs_pkg::IDX_DAC_CUR;
  wire        det_on     = ~adc_path_reg[codec_regs_pkg::BIT_DET_OFF];
  wire        err_evt    = det_on & bus_error_i;
  wire        err_rd     = bus.rd & hit_adc;

  wire [7:0]  adc_rd_val = (adc_path_reg & codec_regs_pkg::ADC_PATH_WMASK) |
                           {7'h00, bus_err_reg};
  // Reserved range and unmapped indices fall through to zero
  wire [7:0]  rd_mux     = hit_page ? {7'h00, page_reg} :
                           hit_adc  ? adc_rd_val :
                           hit_byp  ? bypass_reg :
                           hit_dac  ? dac_cur_reg :
                           codec_regs_pkg::RESET_VAL;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      adc_path_reg <= codec_regs_pkg::RESET_VAL;
      bypass_reg   <= codec_regs_pkg::RESET_VAL;
      dac_cur_reg  <= codec_regs_pkg::RESET_VAL;
      page_reg     <= 1'b0;
      rdata_reg    <= codec_regs_pkg::RESET_VAL;
    end else begin
      if (bus.wr && hit_page)
        page_reg <= bus.wdata[codec_regs_pkg::BIT_PAGE];
      // Read-only bits keep their value under any write
      if (bus.wr && hit_adc)
        adc_path_reg <= bus.wdata & codec_regs_pkg::ADC_PATH_WMASK;
      if (bus.wr && hit_byp)
        bypass_reg <= bus.wdata;
      if (bus.wr && hit_dac)
        dac_cur_reg <= bus.wdata & codec_regs_pkg::DAC_CUR_WMASK;
      if (bus.rd)
        rdata_reg <= rd_mux;
    end
  end

  // Error flag: a new error in the reading cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (srst_i)
      bus_err_reg <= 1'b0;
    else if (err_evt)
      bus_err_reg <= 1'b1;
    else if (err_rd)
      bus_err_reg <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Outputs to the analog and filter sections
  // ----------------------------------------------------------------------
  assign bus.rdata            = rdata_reg;
  assign page_one_o           = page_reg;
  assign left_prog_coef_o     = hpf_enable_i &
                                adc_path_reg[codec_regs_pkg::BIT_COEF_LEFT];
  assign right_prog_coef_o    = hpf_enable_i &
                                adc_path_reg[codec_regs_pkg::BIT_COEF_RIGHT];
  assign left_analog_mic_o    = adc_path_reg[codec_regs_pkg::BIT_DECIM_HI];
  assign right_analog_mic_o   = adc_path_reg[codec_regs_pkg::BIT_DECIM_LO];
  assign prog_filter_on_adc_o = dacs_powered_down_i &
                                adc_path_reg[codec_regs_pkg::BIT_FILT_PATH];
  // Self-clearing of the bus fault is only allowed while detection is on
  assign bus_error_clear_o    = err_evt;
  assign right_bypass_o       = bypass_reg[7:4];
  assign left_bypass_o        = bypass_reg[3:0];
  assign dac_current_trim_o   = dac_cur_reg[codec_regs_pkg::BIT_DAC_HI:
                                            codec_regs_pkg::BIT_DAC_LO];

endmodule
`default_nettype wire

// ### core/codec_regs_pkg.sv
package codec_regs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W          = 7;
  localparam int          DATA_W          = 8;
  localparam logic [6:0]  IDX_PAGE        = 7'h00;
  localparam logic [6:0]  IDX_ADC_PATH    = 7'h6b;
  localparam logic [6:0]  IDX_BYPASS      = 7'h6c;
  localparam logic [6:0]  IDX_DAC_CUR     = 7'h6d;
  localparam logic [6:0]  IDX_RSVD_FIRST  = 7'h6e;
  localparam logic [7:0]  RESET_VAL       = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int          BIT_COEF_LEFT   = 7;
  localparam int          BIT_COEF_RIGHT  = 6;
  localparam int          BIT_DECIM_HI    = 5;
  localparam int          BIT_DECIM_LO    = 4;
  localparam int          BIT_FILT_PATH   = 3;
  localparam int          BIT_DET_OFF     = 2;
  localparam int          BIT_BUS_ERR     = 0;
  localparam int          BIT_PAGE        = 0;
  localparam int          BIT_DAC_HI      = 7;
  localparam int          BIT_DAC_LO      = 6;
  localparam logic [7:0]  ADC_PATH_WMASK  = 8'hfc;
  localparam logic [7:0]  DAC_CUR_WMASK   = 8'hc0;
  localparam logic [7:0]  PAGE_WMASK      = 8'h01;

  // ----------------------------------------------------------------------
  // Host controller register offsets (word per register)
  // ----------------------------------------------------------------------
  localparam logic [3:0]  HOST_CMD        = 4'h0;
  localparam logic [3:0]  HOST_RDATA      = 4'h1;
  localparam logic [3:0]  HOST_STATUS     = 4'h2;
  localparam logic [3:0]  HOST_IRQ_EN     = 4'h3;
  localparam logic [3:0]  HOST_IRQ_CLR    = 4'h4;
  localparam int          CMD_WR_BIT      = 16;
  localparam int          CMD_RD_BIT      = 17;
  localparam int          ST_DONE         = 0;
  localparam int          ST_REFUSED      = 1;
  localparam int          ST_PAGE_BAD     = 2;
  localparam int          NUM_EVT         = 3;

  typedef enum logic [3:0] {
    H_IDLE   = 4'b0001,
    H_ISSUE  = 4'b0010,
    H_WAIT   = 4'b0100,
    H_VERIFY = 4'b1000
  } host_state_e;

endpackage

// ### verification/codec_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_chk (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] rdata
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // --------------------------------------------------------------
  // Shadow copies of what the host has stored
  // --------------------------------------------------------------
  logic       page_reg;
  logic [7:0] byp_reg;
  logic [5:0] adc_reg;
  logic [1:0] dac_reg;
  wire        pg0_wr = wr && !page_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      page_reg <= 1'b0;
      byp_reg  <= 8'h00;
      adc_reg  <= 6'h00;
      dac_reg  <= 2'h0;
    end else begin
      if (wr && addr == 7'h00) page_reg <= wdata[0];
      if (pg0_wr && addr == 7'h6c) byp_reg <= wdata;
      if (pg0_wr && addr == 7'h6b) adc_reg <= wdata[7:2];
      if (pg0_wr && addr == 7'h6d) dac_reg <= wdata[7:6];
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  a_page_readback: assert property (wr && addr == 7'h00 |-> ##1 rd && addr == 7'h00) else $error("page write not read back");
  a_page_read: assert property (rd && addr == 7'h00 |=> rdata == {7'h00, page_reg}) else $error("page register read wrong");
  a_rsvd_read: assert property (rd && !page_reg && addr >= 7'h6e |=> rdata == 8'h00) else $error("reserved index not zero");
  a_rsvd_no_write: assert property (pg0_wr |-> addr < 7'h6e) else $error("reserved index written");
  a_page1_hides: assert property (rd && page_reg && addr != 7'h00 |=> rdata == 8'h00) else $error("page zero seen on page one");
  a_adc_read: assert property (rd && !page_reg && addr == 7'h6b |=> rdata[7:2] == adc_reg && !rdata[1]) else $error("adc path read wrong");
  a_byp_read: assert property (rd && !page_reg && addr == 7'h6c |=> rdata == byp_reg) else $error("bypass read wrong");
  a_dac_read: assert property (rd && !page_reg && addr == 7'h6d |=> rdata == {dac_reg, 6'h00}) else $error("dac current read wrong");
  c_page_one_read: cover property (rd && page_reg);
  c_rsvd_read: cover property (rd && addr >= 7'h6e);
  c_byp_write: cover property (wr && addr == 7'h6c);
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [3:0]  sw_addr_i = 4'h0;
  logic [31:0] sw_wdata_i = 32'h0000_0000;
  logic        sw_wr_i = 1'b0;
  logic        sw_rd_i = 1'b0;
  logic        bus_error_i = 1'b0;
  logic        dacs_i = 1'b1;
  logic        hpf_i = 1'b1;
  logic [31:0] sw_rdata_o;
  logic        irq_o, pg, lpc, rpc, lmic, rmic, pflt, eclr;
  logic [3:0]  rbyp, lbyp;
  logic [1:0]  trim;
  logic [7:0]  d, v;
  logic        irq_en = 1'b1;
  int          err_total = 0;
  int          total_checks = 0;
  int          i;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s expected %h seen %h", n, e, g); end end
  always #2 clk_i = ~clk_i;
  codec_ctrl_if bus_if ();
  codec_host_ctrl codec_host_ctrl_inst (.clk_i(clk_i), .srst_i(srst_i),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
    .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .irq_o(irq_o), .bus(bus_if));
  codec_misc_config_page_regs codec_misc_config_page_regs_inst (
    .clk_i(clk_i), .srst_i(srst_i), .bus(bus_if), .bus_error_i(bus_error_i),
    .dacs_powered_down_i(dacs_i), .hpf_enable_i(hpf_i), .page_one_o(pg),
    .left_prog_coef_o(lpc), .right_prog_coef_o(rpc), .left_analog_mic_o(lmic),
    .right_analog_mic_o(rmic), .prog_filter_on_adc_o(pflt),
    .bus_error_clear_o(eclr), .right_bypass_o(rbyp), .left_bypass_o(lbyp),
    .dac_current_trim_o(trim));
  codec_ctrl_chk codec_ctrl_chk_inst (.clk_i(clk_i), .srst_i(srst_i),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
    .rd(bus_if.rd), .rdata(bus_if.rdata));
  // --------------------------------------------------------------
  // Software port cycles
  // --------------------------------------------------------------
  task automatic sw(input logic [3:0] a, input logic [31:0] w, input bit r);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= w;
    if (r) sw_rd_i <= 1'b1;
    else sw_wr_i <= 1'b1;
    @(posedge clk_i);
    sw_rd_i <= 1'b0;
    sw_wr_i <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Polls the sticky status, so a fast or slow answer both pass
  task automatic xfer(input logic [31:0] c, input logic [2:0] st);
    int n;
    logic [2:0] s;
    sw(4'h0, c, 0);
    s = 3'h0;
    for (n = 0; n < 20 && s[1:0] == 2'h0; n++) begin
      sw(4'h2, 32'h0, 1);
      s = sw_rdata_o[2:0];
    end
    `CHK("status", st, s)
    `CHK("irq", irq_en, irq_o)
    sw(4'h4, 32'h7, 0);
    sw(4'h1, 32'h0, 1);
    d = sw_rdata_o[7:0];
    `CHK("irq clear", 1'b0, irq_o)
    // A used-up poll bound is a mismatch of its own
    if (n == 20) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] w);
    xfer({14'h0, 2'b01, 1'b0, a, w}, 3'h1);
  endtask
  task automatic rreg(input logic [6:0] a, input logic [7:0] e);
    xfer({14'h0, 2'b10, 1'b0, a, 8'h00}, 3'h1);
    `CHK("rdata", e, d)
  endtask
  task automatic pulse(input logic e);
    @(posedge clk_i);
    bus_error_i <= 1'b1;
    #1;
    `CHK("error clear", e, eclr)
    @(posedge clk_i);
    bus_error_i <= 1'b0;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    sw(4'h3, 32'h7, 0);
    rreg(7'h6c, 8'h00);
    rreg(7'h6d, 8'h00);
    `CHK("outputs", 16'h0000, {lpc, rpc, lmic, rmic, pflt, rbyp, lbyp, trim, pg})
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      v = {i[1:0], i[1:0], i[0], 3'b000};
      wreg(7'h6b, v | 8'h01);
      rreg(7'h6b, v);
      `CHK("adc", v[7:3], {lpc, rpc, lmic, rmic, pflt})
    end
    @(posedge clk_i);
    hpf_i <= 1'b0;
    dacs_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK("gated", 3'h0, {lpc, rpc, pflt})
    @(posedge clk_i);
    hpf_i <= 1'b1;
    dacs_i <= 1'b1;
    $display("adc path done");
    wreg(7'h6b, 8'h00);
    pulse(1'b1);
    rreg(7'h6b, 8'h01);
    rreg(7'h6b, 8'h00);
    wreg(7'h6b, 8'h04);
    pulse(1'b0);
    rreg(7'h6b, 8'h04);
    $display("bus error done");
    for (i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      wreg(7'h6c, v);
      rreg(7'h6c, v);
      `CHK("bypass", v, {rbyp, lbyp})
    end
    $display("bypass done");
    for (i = 0; i < 3; i++) begin
      v = {i[1], i[1] | i[0], 6'h00};
      wreg(7'h6d, v);
      rreg(7'h6d, v);
      `CHK("trim", v[7:6], trim)
    end
    sw(4'h3, 32'h0, 0);
    irq_en = 1'b0;
    wreg(7'h6d, 8'h40);
    sw(4'h3, 32'h7, 0);
    irq_en = 1'b1;
    $display("dac current done");
    rreg(7'h6e, 8'h00);
    rreg(7'h7f, 8'h00);
    xfer({14'h0, 2'b01, 1'b1, 7'h6e, 8'h00}, 3'h2);
    $display("reserved done");
    wreg(7'h00, 8'h01);
    `CHK("page", 1'b1, pg)
    rreg(7'h00, 8'h01);
    rreg(7'h6c, 8'h00);
    // Coefficient pair, high byte then low; page one lies outside this slice
    wreg(7'h01, 8'h6b);
    wreg(7'h02, 8'he3);
    rreg(7'h01, 8'h00);
    wreg(7'h00, 8'h00);
    rreg(7'h6c, 8'h80);
    $display("page select done");
    report_and_stop();
  end
endmodule
`default_nettype wire
